// ---- inc/ptr_defs.svh ----
`ifndef PTR_DEFS_SVH
`define PTR_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_PTR 5'h04
`define REG_RATE 5'h08
`define REG_OFS 5'h0C
`define REG_STEP 5'h10
`define REG_STATUS 5'h14
`define REG_REPORT 5'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_WIDTH 10
`define SEL_LSB 0
`define VAL_LSB 16
`define STEP_DOWN_BIT 0
`define STEP_COARSE_BIT 1
`define RPT_VALID_BIT 31
`define RPT_NEG_BIT 30
`define STAT_NDF_BIT 12

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_RESET 10'h000
`define STS_PTR_RESET 10'h20A

// ----------------------------------------------------------------------
// Pointer locations and flag codes
// ----------------------------------------------------------------------
`define STS_MIN 10'h000
`define STS_MAX 10'h30E
`define STS_DEF 10'h20A
`define STS_ILL 10'h30F
`define VT_MAX 10'h067
`define VT_DEF 10'h04E
`define VT_ILL 10'h068
`define NDF_SET 4'h9
`define NDF_NORM 4'h6

// ----------------------------------------------------------------------
// Movement periods and frequency offsets
// ----------------------------------------------------------------------
`define RATE_48_MS 14'h0030
`define RATE_FAST_FRAMES 14'h0010
`define RATE_10000_MS 14'h2710
`define RATE_50_MS 14'h0032
`define RATE_USER_MIN 14'h0001
`define OFS_MAX 11'h3E8
`define OFS_STRESS 11'h02E
`define OFS_COARSE 11'h064
`define OFS_FINE 11'h001
`define OFS_THRESH 26'h0989680
`define STS_LOC_PER_FRAME 26'h000030F
`define VT_LOC_PER_FRAME 26'h000001A
`define STS_REPORT_K 26'h0185C08
`define VT_REPORT_K 26'h2DD987B
`define US_PER_MS 24'h0003E8
`define FAST_RATE_MS 24'h000002

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define FRAME_PERIOD_NS 125000
`define FRAME_CYCLES (`FRAME_PERIOD_NS / `CLK_PERIOD_NS)
`define MS_PERIOD_NS 1000000
`define MS_CYCLES (`MS_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ---- inc/ptr_pkg.sv ----
package ptr_pkg;

	typedef enum logic [1:0] {
		DIR_INC = 2'h0,
		DIR_DEC = 2'h1,
		DIR_ALT = 2'h2,
		DIR_RSV = 2'h3
	} dir_t;

	typedef enum logic [2:0] {
		PSEL_MIN = 3'h0,
		PSEL_MAX = 3'h1,
		PSEL_DEF = 3'h2,
		PSEL_ILL = 3'h3,
		PSEL_USER = 3'h4
	} ptr_sel_t;

	typedef enum logic [2:0] {
		RSEL_48 = 3'h0,
		RSEL_FAST = 3'h1,
		RSEL_10000 = 3'h2,
		RSEL_50 = 3'h3,
		RSEL_USER = 3'h4
	} rate_sel_t;

	typedef enum logic [2:0] {
		OSEL_MAX = 3'h0,
		OSEL_POS = 3'h1,
		OSEL_NEG = 3'h2,
		OSEL_ZERO = 3'h3,
		OSEL_USER = 3'h4
	} ofs_sel_t;

	typedef enum logic [1:0] {
		DIV_IDLE = 2'h0,
		DIV_RUN = 2'h1,
		DIV_DONE = 2'h2
	} div_state_t;

	typedef struct packed {
		logic async_vt;
		logic payload_mode;
		logic cont_en;
		dir_t dir;
		logic [1:0] size;
		logic ndf_en;
		logic vt;
		logic freq_mode;
	} ptr_cfg_t;

	typedef struct packed {
		logic [3:0] ndf;
		logic [1:0] size;
		logic [9:0] value;
	} ptr_word_t;

endpackage : ptr_pkg

// ---- verilog/ptr_move_timer.sv ----
`timescale 1ns/1ps
`include "ptr_defs.svh"

module ptr_move_timer #(
	parameter int FRAME_CYCLES = `FRAME_CYCLES,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Period control
	input wire logic restart_i,
	input wire logic use_frames_i,
	input wire logic [13:0] period_i,
	// Line rate adjustment
	input wire logic stretch_i,
	input wire logic shrink_i,
	// Events
	output logic frame_o,
	output logic tick_o
);

	localparam int FW = $clog2(FRAME_CYCLES + 2);
	localparam int MW = $clog2(MS_CYCLES + 1);
	localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);
	localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);

	generate
		if (FRAME_CYCLES < 4 || MS_CYCLES < 2) begin : g_bad
			$error("ptr_move_timer: counts too small");
		end
	endgenerate

	logic [FW-1:0] fcnt_r;
	logic [MW-1:0] mcnt_r;
	logic [13:0] pcnt_r;
	logic stretch_r;
	logic shrink_r;

	wire frame_w = (fcnt_r == '0);
	wire ms_w = (mcnt_r == '0);
	wire step_w = use_frames_i ? frame_w : ms_w;
	wire due_w = step_w && (pcnt_r + 14'h0001 >= period_i);
	wire [FW-1:0] frame_len_w = stretch_r ? FRAME_LAST + FW'(1) :
		shrink_r ? FRAME_LAST - FW'(1) : FRAME_LAST;

	// ----------------------------------------------------------------------
	// Frame timer; a pending line adjustment lengthens or shortens a frame.
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fcnt_r <= FRAME_LAST;
			stretch_r <= 1'b0;
			shrink_r <= 1'b0;
		end else begin
			fcnt_r <= frame_w ? frame_len_w : fcnt_r - FW'(1);
			stretch_r <= stretch_i || (stretch_r && !frame_w);
			shrink_r <= shrink_i || (shrink_r && !frame_w);
		end
	end

	// ----------------------------------------------------------------------
	// Millisecond prescaler and movement period counter.
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || restart_i) begin
			mcnt_r <= MS_LAST;
			pcnt_r <= 14'h0000;
			tick_o <= 1'b0;
		end else begin
			mcnt_r <= ms_w ? MS_LAST : mcnt_r - MW'(1);
			pcnt_r <= due_w ? 14'h0000 : pcnt_r + 14'(step_w);
			tick_o <= due_w;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			frame_o <= 1'b0;
		end else begin
			frame_o <= frame_w;
		end
	end

endmodule : ptr_move_timer

// ---- verilog/sonet_pointer_offset_gen.sv ----
// Function
// - STS minimum preset moves the pointer to zero at once.
// - STS maximum preset moves the pointer to 782 at once.
// - STS default preset moves the pointer to 522 at once.
// - STS illegal preset sends pointer value 783 at once.
// - A user pointer value is applied when its entry is committed.
// - VT maximum preset moves the VT pointer to 103 at once.
// - VT default preset moves the VT pointer to 78 at once.
// - VT illegal preset sends VT pointer value 104 at once.
// - A setting chooses new data flag or normal flag on jumps.
// - The two pointer size bits are selectable from 00 to 11.
// - The 48 ms period, async VT only, moves once per 48 ms.
// - The fastest period moves the pointer once per sixteen frames.
// - The slowest period moves the pointer once per ten seconds.
// - The default period moves the pointer once per 50 ms.
// - A user period of 1 to 10000 ms is kept exactly.
// - Moves increment, decrement or alternate as the direction says.
// - Increment or decrement moves report the equivalent ppm offset.
// - Timing mode offsets the payload or the line rate instead.
// - Line offset changes the line rate, the pointer stays fixed.
// - Payload offset shifts payload rate, the pointer moves as result.
// - Offset presets are +100, +4.6, -4.6 and zero ppm.
// - User offset steps by 10.0 or 0.1 ppm within 100 ppm.
// - Frequency offset mode reports the equivalent movement period.
// - Pointer jumps happen at once, with or without new data flag.
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "ptr_defs.svh"

module sonet_pointer_offset_gen #(
	parameter int FRAME_CYCLES = `FRAME_CYCLES,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Transmit pointer
	output ptr_pkg::ptr_word_t ptr_word_o,
	output logic frame_start_o,
	output logic just_inc_o,
	output logic just_dec_o
);

	generate
		if (FRAME_CYCLES < 16 || MS_CYCLES < 16) begin : g_bad
			$error("sonet_pointer_offset_gen: counts too small");
		end
	endgenerate

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : be_merge

	function automatic logic [9:0] max_loc(input logic vt);
		return vt ? `VT_MAX : `STS_MAX;
	endfunction : max_loc

	function automatic logic [9:0] step_ptr(input logic [9:0] v,
		input logic vt, input logic up);
		logic [9:0] res;
		res = v;
		if (up) begin
			res = (v >= max_loc(vt)) ? 10'h000 : v + 10'h001;
		end else begin
			res = (v == 10'h000 || v > max_loc(vt)) ? max_loc(vt) :
				v - 10'h001;
		end
		return res;
	endfunction : step_ptr

	function automatic logic [9:0] preset_loc(input ptr_pkg::ptr_sel_t sel,
		input logic vt, input logic [9:0] user);
		logic [9:0] res;
		res = user;
		case (sel)
			ptr_pkg::PSEL_MIN: res = `STS_MIN;
			ptr_pkg::PSEL_MAX: res = max_loc(vt);
			ptr_pkg::PSEL_DEF: res = vt ? `VT_DEF : `STS_DEF;
			ptr_pkg::PSEL_ILL: res = vt ? `VT_ILL : `STS_ILL;
			default: res = user;
		endcase
		return res;
	endfunction : preset_loc

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	ptr_pkg::ptr_cfg_t cfg_r;
	ptr_pkg::rate_sel_t rate_sel_r;
	ptr_pkg::ofs_sel_t ofs_sel_r;
	ptr_pkg::div_state_t div_st_r;
	logic [13:0] rate_user_r;
	logic signed [10:0] ofs_user_r;
	logic [9:0] jump_val_r;
	logic jump_pend_r;
	logic move_pend_r;
	logic move_up_r;
	logic alt_up_r;
	logic signed [25:0] acc_r;
	logic [25:0] quo_r;
	logic [26:0] rem_r;
	logic [23:0] den_r;
	logic [4:0] div_cnt_r;
	logic recalc_r;
	logic [31:0] report_r;
	logic rpt_neg_r;
	logic rpt_ok_r;

	// ----------------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------------
	wire req_w = avs_read_i || avs_write_i;
	wire wr_w = avs_write_i && !avs_waitrequest_o;
	wire [31:0] wd_w = avs_writedata_i;
	wire wr_ctrl_w = wr_w && avs_address_i == `REG_CTRL;
	wire wr_ptr_w = wr_w && avs_address_i == `REG_PTR;
	wire wr_rate_w = wr_w && avs_address_i == `REG_RATE;
	wire wr_ofs_w = wr_w && avs_address_i == `REG_OFS;
	wire wr_step_w = wr_w && avs_address_i == `REG_STEP;
	wire [31:0] ctrl_rd_w = {22'h000000, cfg_r};
	wire [31:0] ptr_rd_w = {6'h00, jump_val_r, 13'h0000, 3'h0};
	wire [31:0] rate_rd_w = {2'h0, rate_user_r, 13'h0000, rate_sel_r};
	wire [31:0] ofs_rd_w = {5'h00, ofs_user_r, 13'h0000, ofs_sel_r};
	wire [31:0] stat_rd_w = {19'h00000, ptr_word_o.ndf == `NDF_SET,
		ptr_word_o.size, ptr_word_o.value};
	wire [31:0] wr_ctrl_v = be_merge(ctrl_rd_w, wd_w, avs_byteenable_i);
	wire [31:0] wr_rate_v = be_merge(rate_rd_w, wd_w, avs_byteenable_i);
	wire [31:0] wr_ofs_v = be_merge(ofs_rd_w, wd_w, avs_byteenable_i);
	wire [13:0] new_rate_w = wr_rate_v[`VAL_LSB +: 14];
	wire rate_ok_w = new_rate_w >= `RATE_USER_MIN &&
		new_rate_w <= `RATE_10000_MS;
	wire signed [10:0] new_ofs_w = wr_ofs_v[`VAL_LSB +: 11];
	wire ofs_ok_w = new_ofs_w <= $signed(`OFS_MAX) &&
		new_ofs_w >= -$signed(`OFS_MAX);

	logic [31:0] rd_mux_w;
	always_comb begin
		case (avs_address_i)
			`REG_CTRL: rd_mux_w = ctrl_rd_w;
			`REG_PTR: rd_mux_w = ptr_rd_w;
			`REG_RATE: rd_mux_w = rate_rd_w;
			`REG_OFS: rd_mux_w = ofs_rd_w;
			`REG_STATUS: rd_mux_w = stat_rd_w;
			`REG_REPORT: rd_mux_w = report_r;
			default: rd_mux_w = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------------
	// Movement period and frequency offset selection
	// ----------------------------------------------------------------------
	wire fast_w = rate_sel_r == ptr_pkg::RSEL_FAST;
	wire r48_ok_w = cfg_r.vt && cfg_r.async_vt;
	logic [13:0] period_w;
	always_comb begin
		case (rate_sel_r)
			ptr_pkg::RSEL_48: period_w = r48_ok_w ? `RATE_48_MS :
				`RATE_50_MS;
			ptr_pkg::RSEL_FAST: period_w = `RATE_FAST_FRAMES;
			ptr_pkg::RSEL_10000: period_w = `RATE_10000_MS;
			ptr_pkg::RSEL_USER: period_w = rate_user_r;
			default: period_w = `RATE_50_MS;
		endcase
	end

	logic signed [10:0] ofs_w;
	always_comb begin
		case (ofs_sel_r)
			ptr_pkg::OSEL_MAX: ofs_w = `OFS_MAX;
			ptr_pkg::OSEL_POS: ofs_w = `OFS_STRESS;
			ptr_pkg::OSEL_NEG: ofs_w = -$signed(`OFS_STRESS);
			ptr_pkg::OSEL_USER: ofs_w = ofs_user_r;
			default: ofs_w = 11'h000;
		endcase
	end

	wire [10:0] step_amt_w = wd_w[`STEP_COARSE_BIT] ? `OFS_COARSE :
		`OFS_FINE;
	wire signed [11:0] stepped_w = wd_w[`STEP_DOWN_BIT] ?
		12'(ofs_user_r) - 12'(step_amt_w) : 12'(ofs_user_r) + 12'(step_amt_w);
	wire step_ok_w = stepped_w <= 12'sh3E8 && stepped_w >= -12'sh3E8;

	// ----------------------------------------------------------------------
	// Frequency offset accumulator
	// ----------------------------------------------------------------------
	logic frame_w;
	logic tick_w;
	wire line_mode_w = cfg_r.freq_mode && !cfg_r.payload_mode;
	wire pay_mode_w = cfg_r.freq_mode && cfg_r.payload_mode;
	wire [25:0] k_w = line_mode_w ? 26'(FRAME_CYCLES) :
		cfg_r.vt ? `VT_LOC_PER_FRAME : `STS_LOC_PER_FRAME;
	wire signed [25:0] ofs_ext_w = {{15{ofs_w[10]}}, ofs_w};
	wire signed [25:0] sum_w = acc_r + ofs_ext_w * $signed(k_w);
	wire slip_pos_w = frame_w && sum_w >= $signed(`OFS_THRESH);
	wire slip_neg_w = frame_w && sum_w <= -$signed(`OFS_THRESH);
	logic signed [25:0] acc_nxt;
	always_comb begin
		acc_nxt = acc_r;
		if (!cfg_r.freq_mode || ofs_w == 11'h000) begin
			acc_nxt = 26'h0000000;
		end else if (slip_pos_w) begin
			acc_nxt = sum_w - $signed(`OFS_THRESH);
		end else if (slip_neg_w) begin
			acc_nxt = sum_w + $signed(`OFS_THRESH);
		end else if (frame_w) begin
			acc_nxt = sum_w;
		end
	end

	// A positive payload offset needs negative justification.
	wire pay_move_w = pay_mode_w && (slip_pos_w || slip_neg_w);
	wire cont_move_w = !cfg_r.freq_mode && cfg_r.cont_en && tick_w;
	wire cont_up_w = cfg_r.dir == ptr_pkg::DIR_ALT ? alt_up_r :
		cfg_r.dir == ptr_pkg::DIR_INC;
	wire restart_w = wr_rate_w || wr_ctrl_w || !cfg_r.cont_en;

	ptr_move_timer #(
		.FRAME_CYCLES(FRAME_CYCLES),
		.MS_CYCLES(MS_CYCLES)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.restart_i(restart_w),
		.use_frames_i(fast_w),
		.period_i(period_w),
		.stretch_i(line_mode_w && slip_neg_w),
		.shrink_i(line_mode_w && slip_pos_w),
		.frame_o(frame_w),
		.tick_o(tick_w)
	);

	// ----------------------------------------------------------------------
	// Registers written by software
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cfg_r <= `CTRL_RESET;
			rate_sel_r <= ptr_pkg::RSEL_50;
			rate_user_r <= `RATE_50_MS;
			ofs_sel_r <= ptr_pkg::OSEL_ZERO;
			ofs_user_r <= 11'h000;
			recalc_r <= 1'b1;
		end else begin
			if (wr_ctrl_w) begin
				cfg_r <= wr_ctrl_v[`CTRL_WIDTH-1:0];
			end
			if (wr_rate_w) begin
				rate_sel_r <= ptr_pkg::rate_sel_t'(wr_rate_v[`SEL_LSB +: 3]);
				if (rate_ok_w) begin
					rate_user_r <= new_rate_w;
				end
			end
			if (wr_ofs_w) begin
				ofs_sel_r <= ptr_pkg::ofs_sel_t'(wr_ofs_v[`SEL_LSB +: 3]);
				if (ofs_ok_w) begin
					ofs_user_r <= new_ofs_w;
				end
			end
			if (wr_step_w && step_ok_w) begin
				ofs_user_r <= stepped_w[10:0];
			end
			recalc_r <= wr_ctrl_w || wr_rate_w || wr_ofs_w || wr_step_w ||
				(recalc_r && div_st_r != ptr_pkg::DIV_IDLE);
		end
	end

	// ----------------------------------------------------------------------
	// Pending pointer changes, applied at the next frame boundary
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			jump_pend_r <= 1'b0;
			jump_val_r <= `STS_PTR_RESET;
			move_pend_r <= 1'b0;
			move_up_r <= 1'b1;
			acc_r <= 26'h0000000;
		end else begin
			acc_r <= acc_nxt;
			if (frame_w) begin
				jump_pend_r <= 1'b0;
				move_pend_r <= 1'b0;
			end
			if (cont_move_w || pay_move_w) begin
				move_pend_r <= 1'b1;
				move_up_r <= pay_move_w ? slip_neg_w : cont_up_w;
			end
			if (wr_ptr_w) begin
				jump_pend_r <= 1'b1;
				jump_val_r <= preset_loc(
					ptr_pkg::ptr_sel_t'(wd_w[`SEL_LSB +: 3]), cfg_r.vt,
					wd_w[`VAL_LSB +: 10]);
			end
		end
	end

	// ----------------------------------------------------------------------
	// Transmitted pointer word
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ptr_word_o <= {`NDF_NORM, 2'b00, `STS_PTR_RESET};
			alt_up_r <= 1'b1;
			just_inc_o <= 1'b0;
			just_dec_o <= 1'b0;
			frame_start_o <= 1'b0;
		end else begin
			frame_start_o <= frame_w;
			just_inc_o <= 1'b0;
			just_dec_o <= 1'b0;
			if (frame_w) begin
				ptr_word_o.size <= cfg_r.size;
				ptr_word_o.ndf <= `NDF_NORM;
				if (jump_pend_r) begin
					ptr_word_o.value <= jump_val_r;
					ptr_word_o.ndf <= cfg_r.ndf_en ? `NDF_SET :
						`NDF_NORM;
				end else if (move_pend_r && !line_mode_w) begin
					ptr_word_o.value <= step_ptr(ptr_word_o.value, cfg_r.vt,
						move_up_r);
					just_inc_o <= move_up_r;
					just_dec_o <= !move_up_r;
					alt_up_r <= !move_up_r;
				end
			end
		end
	end

	// ----------------------------------------------------------------------
	// Equivalent rate report: K / period in ppm tenths, or K / offset in us.
	// ----------------------------------------------------------------------
	wire [25:0] div_k_w = cfg_r.vt ? `VT_REPORT_K : `STS_REPORT_K;
	wire [10:0] ofs_abs_w = ofs_w[10] ? 11'(-ofs_w) : 11'(ofs_w);
	wire [23:0] per_us_w = fast_w ? `FAST_RATE_MS * `US_PER_MS :
		24'(period_w) * `US_PER_MS;
	wire [23:0] div_den_w = cfg_r.freq_mode ? 24'(ofs_abs_w) :
		per_us_w;
	wire div_ok_w = cfg_r.freq_mode ? ofs_w != 11'h000 :
		cfg_r.dir != ptr_pkg::DIR_ALT;
	wire div_neg_w = cfg_r.freq_mode ? ofs_w[10] :
		cfg_r.dir == ptr_pkg::DIR_INC;
	wire [26:0] rem_sh_w = {rem_r[25:0], quo_r[25]};
	wire rem_ge_w = rem_sh_w >= {3'h0, den_r};

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			div_st_r <= ptr_pkg::DIV_IDLE;
			quo_r <= 26'h0000000;
			rem_r <= 27'h0000000;
			den_r <= 24'h000001;
			div_cnt_r <= 5'h00;
			rpt_neg_r <= 1'b0;
			rpt_ok_r <= 1'b0;
			report_r <= 32'h00000000;
		end else begin
			case (div_st_r)
				ptr_pkg::DIV_IDLE: begin
					if (recalc_r) begin
						quo_r <= div_k_w;
						rem_r <= 27'h0000000;
						den_r <= div_den_w == 24'h000000 ? 24'h000001 : div_den_w;
						rpt_ok_r <= div_ok_w;
						rpt_neg_r <= div_neg_w;
						div_cnt_r <= 5'h19;
						div_st_r <= ptr_pkg::DIV_RUN;
					end
				end
				ptr_pkg::DIV_RUN: begin
					rem_r <= rem_ge_w ? rem_sh_w - {3'h0, den_r} : rem_sh_w;
					quo_r <= {quo_r[24:0], rem_ge_w};
					div_cnt_r <= div_cnt_r - 5'h01;
					if (div_cnt_r == 5'h00) begin
						div_st_r <= ptr_pkg::DIV_DONE;
					end
				end
				ptr_pkg::DIV_DONE: begin
					report_r <= {rpt_ok_r, rpt_neg_r, 4'h0, quo_r};
					div_st_r <= ptr_pkg::DIV_IDLE;
				end
				default: div_st_r <= ptr_pkg::DIV_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Avalon handshake: one wait state, then the transfer completes.
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			avs_waitrequest_o <= !(req_w && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o) begin
				avs_readdata_o <= rd_mux_w;
			end
		end
	end

endmodule : sonet_pointer_offset_gen

// ---- dv/sonet_pointer_offset_gen_checker.sv ----
`timescale 1ns/1ps
`include "ptr_defs.svh"
module ptr_gen_checker #(
	parameter int FRAME_CYCLES = `FRAME_CYCLES,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire ptr_pkg::ptr_word_t ptr_word_o,
	input wire logic frame_start_o,
	input wire logic just_inc_o,
	input wire logic just_dec_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic [15:0] gap_r;
	wire logic [9:0] val = ptr_word_o.value;
	always_ff @(posedge clk_sys_i)
		gap_r <= (rst_i || frame_start_o) ? 16'h0000 : gap_r + 16'h0001;
	chk_wait_one: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("waitrequest not low after one cycle");
	chk_wait_rest: assert property (
		!(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("waitrequest low without request");
	chk_rd_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data changed without read");
	chk_word_frame: assert property (!$stable(ptr_word_o) |-> frame_start_o)
		else $error("pointer word changed off frame boundary");
	chk_move_frame: assert property (
		(just_inc_o || just_dec_o) |-> frame_start_o && !(just_inc_o && just_dec_o))
		else $error("move pulse off frame boundary");
	chk_inc_one: assert property (
		just_inc_o |-> val == $past(val) + 10'h001 || val == 10'h000)
		else $error("increment not by one");
	chk_dec_one: assert property (just_dec_o |-> val == $past(val) - 10'h001 ||
		val == `STS_MAX || val == `VT_MAX)
		else $error("decrement not by one");
	chk_flag_code: assert property (
		ptr_word_o.ndf == `NDF_NORM || ptr_word_o.ndf == `NDF_SET)
		else $error("illegal flag code");
	chk_frame_len: assert property (gap_r < 16'(FRAME_CYCLES + 2))
		else $error("frame pulse missing");
	cov_inc: cover property (just_inc_o);
	cov_dec: cover property (just_dec_o);
	cov_ndf: cover property (ptr_word_o.ndf == `NDF_SET);
endmodule : ptr_gen_checker
bind sonet_pointer_offset_gen ptr_gen_checker #(.FRAME_CYCLES(FRAME_CYCLES),
	.MS_CYCLES(MS_CYCLES)) chk_u (.clk_sys_i, .rst_i, .avs_read_i,
	.avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ptr_word_o,
	.frame_start_o, .just_inc_o, .just_dec_o);

// ---- dv/ne_model.sv ----
`timescale 1ns/1ps
module ne_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic frame_start_i,
	input wire ptr_pkg::ptr_word_t word_i,
	input wire logic inc_i,
	input wire logic dec_i,
	output ptr_pkg::ptr_word_t rx_word_o,
	output logic [15:0] n_inc_o,
	output logic [15:0] n_dec_o,
	output logic [15:0] n_ndf_o
);
	// The receiver only trusts the pointer word at the frame pulse.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_word_o <= '0;
			n_inc_o <= 16'h0000;
			n_dec_o <= 16'h0000;
			n_ndf_o <= 16'h0000;
		end else if (frame_start_i) begin
			rx_word_o <= word_i;
			n_inc_o <= n_inc_o + 16'(inc_i);
			n_dec_o <= n_dec_o + 16'(dec_i);
			n_ndf_o <= n_ndf_o + 16'(word_i.ndf == 4'h9);
		end
	end
endmodule : ne_model

// ---- dv/tb_sonet_pointer_offset_gen.sv ----
`timescale 1ns/1ps
`include "ptr_defs.svh"
module tb_sonet_pointer_offset_gen;
	logic clk_sys_i, rst_i, avs_read_i, avs_write_i;
	logic [4:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	logic [3:0] avs_byteenable_i;
	logic avs_waitrequest_o, frame_start_o, just_inc_o, just_dec_o;
	ptr_pkg::ptr_word_t ptr_word_o, rx;
	logic [15:0] n_inc, n_dec, n_ndf;
	int checks = 0;
	int n_mismatch = 0;
	sonet_pointer_offset_gen #(.FRAME_CYCLES(64), .MS_CYCLES(20)) dut_u (
		.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .ptr_word_o, .frame_start_o, .just_inc_o,
		.just_dec_o);
	ne_model ne_u (.clk_sys_i, .rst_i, .frame_start_i(frame_start_o),
		.word_i(ptr_word_o), .inc_i(just_inc_o), .dec_i(just_dec_o),
		.rx_word_o(rx), .n_inc_o(n_inc), .n_dec_o(n_dec), .n_ndf_o(n_ndf));
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : bus
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic frm(input int k);
		repeat (k) begin
			do begin
				@(posedge clk_sys_i);
			end while (frame_start_o !== 1'b1);
		end
	endtask : frm
	task automatic jump(input logic [2:0] s, input logic [9:0] v);
		bus(1'b1, `REG_PTR, {6'h00, v, 13'h0000, s});
		frm(3);
	endtask : jump
	task automatic t_reset();
		chk("word", 32'h0000620A, {16'h0000, ptr_word_o});
		bus(1'b0, `REG_STATUS, 32'h00000000);
		chk("status", 32'h0000020A, q);
		bus(1'b0, `REG_RATE, 32'h00000000);
		chk("rate rst", 32'h00320003, q);
		bus(1'b0, 5'h1C, 32'h00000000);
		chk("unmapped", 32'h00000000, q);
	endtask : t_reset
	task automatic t_sts();
		logic [9:0] e [5] = '{`STS_MIN, `STS_MAX, `STS_DEF, `STS_ILL, 10'h123};
		bus(1'b1, `REG_CTRL, 32'h00000000);
		for (int i = 0; i < 5; i++) begin
			jump(3'(i), 10'h123);
			chk("sts", {22'h0, e[i]}, {22'h0, rx.value});
		end
		chk("ndf off", 32'h0, {16'h0, n_ndf});
	endtask : t_sts
	task automatic t_vt();
		logic [9:0] e [4] = '{`STS_MIN, `VT_MAX, `VT_DEF, `VT_ILL};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `REG_CTRL, {27'h0, 2'(i), 3'h2});
			jump(3'(i), 10'h000);
			chk("vt", {22'h0, e[i]}, {22'h0, rx.value});
			chk("size", 32'(i), {30'h0, rx.size});
		end
		bus(1'b1, `REG_CTRL, 32'h00000004);
		jump(ptr_pkg::PSEL_DEF, 10'h000);
		chk("ndf", {22'h1, `STS_DEF}, {6'h0, n_ndf, rx.value});
	endtask : t_vt
	task automatic t_cont();
		bus(1'b1, `REG_CTRL, 32'h00000000);
		jump(ptr_pkg::PSEL_USER, 10'h30D);
		bus(1'b1, `REG_RATE, 32'h00000001);
		bus(1'b1, `REG_CTRL, 32'h00000080);
		frm(40);
		chk("inc", {16'h2, 6'h0, 10'h000}, {n_inc, 6'h0, rx.value});
		bus(1'b0, `REG_REPORT, 32'h00000000);
		chk("rpt inc", 32'h3, {30'h0, q[31:30]});
		bus(1'b1, `REG_CTRL, 32'h000000A0);
		frm(24);
		chk("dec", {16'h1, 6'h0, `STS_MAX}, {n_dec, 6'h0, rx.value});
		bus(1'b1, `REG_CTRL, 32'h000000C0);
		frm(40);
		chk("alt", {16'h3, 16'h2}, {n_inc, n_dec});
		bus(1'b0, `REG_REPORT, 32'h00000000);
		chk("rpt alt", 32'h0, {31'h0, q[31]});
	endtask : t_cont
	task automatic t_freq();
		bus(1'b1, `REG_OFS, 32'h00000000);
		bus(1'b1, `REG_CTRL, 32'h00000001);
		frm(30);
		chk("line", {16'h3, 16'h2}, {n_inc, n_dec});
		bus(1'b1, `REG_CTRL, 32'h00000101);
		frm(40);
		chk("pay", 32'h1, {31'h0, n_dec > 16'h2 && n_inc == 16'h3});
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `REG_OFS, 32'(i));
			repeat (40) @(posedge clk_sys_i);
			bus(1'b0, `REG_REPORT, 32'h00000000);
			chk("rpt ofs", {30'h0, i != 3, i == 2}, {30'h0, q[31:30]});
		end
	endtask : t_freq
	task automatic t_user();
		bus(1'b1, `REG_RATE, 32'h00050004);
		bus(1'b1, `REG_RATE, 32'h27110004);
		bus(1'b0, `REG_RATE, 32'h00000000);
		chk("rate user", 32'h00050004, q);
		bus(1'b1, `REG_OFS, 32'h03E80004);
		bus(1'b1, `REG_STEP, 32'h00000002);
		bus(1'b1, `REG_STEP, 32'h00000003);
		bus(1'b1, `REG_STEP, 32'h00000001);
		bus(1'b0, `REG_OFS, 32'h00000000);
		chk("ofs user", 32'h03830004, q);
	endtask : t_user
	task automatic final_report();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		n_mismatch++;
		final_report();
	end
	initial begin
		rst_i <= 1'b1;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		avs_address_i <= 5'h00;
		avs_writedata_i <= 32'h00000000;
		avs_byteenable_i <= 4'hF;
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset();
		t_sts();
		t_vt();
		t_cont();
		t_freq();
		t_user();
		final_report();
	end
endmodule : tb_sonet_pointer_offset_gen
